// >>> lcd_panel_config_modulation.sv
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
module lcd_panel_config_modulation (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Raw shift clock, from outside the clk domain
  input  wire logic        shift_clock_in,
  // Panel timing from the sequencer, same clock, levels
  input  wire logic        frame_pulse,
  input  wire logic        line_pulse,
  // Pixel data from the pipeline, same clock
  input  wire logic [17:0] pixel_data_in,
  // Panel side
  output logic             pixel_shift_clock,
  output logic             modulation_pin,
  output logic      [17:0] panel_data,
  // Mode flags for the data formatter
  output logic             passive_matrix_panel,
  output logic             active_matrix_panel,
  output logic             reflective_hires_tft,
  output logic             hires_ps_mode,
  output logic             colour_panel,
  output logic             format_two,
  output logic      [1:0]  data_width
);
  import lcd_cfg_pkg::*;

  logic [31:0] panel_cfg;
  logic        sclk_s;
  logic        frame_q;
  logic        line_q;
  logic        mod_level;
  logic [5:0]  line_count;

  // Address decode and strobes
  wire hit_cfg  = (reg_addr == OFF_PANEL_CFG);
  wire hit_stat = (reg_addr == OFF_MOD_STATUS);
  wire wr_cfg   = reg_wr && hit_cfg;

  // Field extraction
  wire [1:0]        type_f  = panel_cfg[TYPE_LSB +: 2];
  wire [1:0]        width_f = panel_cfg[WIDTH_LSB +: 2];
  wire [RATE_W-1:0] rate_f  = panel_cfg[RATE_LSB +: RATE_W];
  wire              inv_f   = panel_cfg[SHIFT_INV_BIT];

  // Panel type decode; reserved code 10 is neither kind
  // Treating code 10 as neither keeps a bad write harmless: no
  // inversion, frozen modulation and dark lanes until fixed
  wire is_passive = (type_f == TYPE_PASSIVE);
  wire is_hires   = (type_f == TYPE_HIRES);
  wire is_active  = (type_f == TYPE_ACTIVE) || is_hires;

  // Inversion applies only to active panels
  wire inv_eff    = inv_f && is_active;
  wire next_sclk  = sclk_s ^ inv_eff;

  // Event detection on the timing levels
  wire frame_evt  = frame_pulse && !frame_q;
  wire line_evt   = line_pulse && !line_q;

  // Width mask per panel kind; reserved code blanks the lanes
  wire [17:0] mask_p = (width_f == WIDTH_NARROW) ? MASK_P4  :
                       (width_f == WIDTH_MID)    ? MASK_P8  :
                       (width_f == WIDTH_WIDE)   ? MASK_P16 :
                       18'h00000;
  wire [17:0] mask_a = (width_f == WIDTH_NARROW) ? MASK_A9  :
                       (width_f == WIDTH_MID)    ? MASK_A12 :
                       (width_f == WIDTH_WIDE)   ? MASK_A18 :
                       18'h00000;
  wire [17:0] lane_mask  = is_active ? mask_a :
                           (is_passive ? mask_p : 18'h00000);
  wire [17:0] next_data  = pixel_data_in & lane_mask;

  // Readback; reserved bit 3 and n/a bits always read zero
  // Idle cycles return zero, so a stale word never looks fresh
  // to a master that samples one cycle late
  wire [31:0] stat_word  = {18'h00000, line_count, 7'h00, mod_level};
  wire [31:0] next_rdata = !reg_rd  ? 32'h00000000 :
                           hit_cfg  ? panel_cfg :
                           hit_stat ? stat_word : 32'h00000000;

  // Shift clock crosses into clk before anyone looks at it
  bit_sync #(
    .W (1)
  ) u_sclk_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in (shift_clock_in),
    .sync_out (sclk_s)
  );

  // Modulation engine; held while no passive panel is chosen
  // Any write to the register restarts the count, even one that
  // keeps the rate; simpler than comparing old and new rate
  ac_mod_gen u_mod (
    .clk                  (clk),
    .sys_rst              (sys_rst),
    .enable               (is_passive),
    .restart              (wr_cfg),
    .rate                 (rate_f),
    .frame_evt            (frame_evt),
    .line_evt             (line_evt),
    .ac_modulation_output (mod_level),
    .line_count           (line_count)
  );

  // Configuration register; bit 3 is never stored
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      panel_cfg <= PANEL_CFG_RESET;
    else if (wr_cfg)
      panel_cfg <= reg_wdata & PANEL_CFG_WMASK;
  end

  // Read data stands one cycle after the strobe
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      reg_rdata <= 32'h00000000;
    else
      reg_rdata <= next_rdata;
  end

  // Timing edge history
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      frame_q <= 1'b0;
      line_q  <= 1'b0;
    end
    else
    begin
      frame_q <= frame_pulse;
      line_q  <= line_pulse;
    end
  end

  // Panel pins, all registered to keep them glitch free
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pixel_shift_clock <= 1'b0;
      modulation_pin    <= 1'b0;
      panel_data        <= 18'h00000;
    end
    else
    begin
      pixel_shift_clock <= next_sclk;
      modulation_pin    <= mod_level;
      panel_data        <= next_data;
    end
  end

  // Mode flags; shift clock adds two cycles of sync delay
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      passive_matrix_panel <= 1'b0;
      active_matrix_panel  <= 1'b0;
      reflective_hires_tft <= 1'b0;
      hires_ps_mode        <= 1'b0;
      colour_panel         <= 1'b0;
      format_two           <= 1'b0;
      data_width           <= 2'h0;
    end
    else
    begin
      passive_matrix_panel <= is_passive;
      active_matrix_panel  <= is_active;
      reflective_hires_tft <= is_hires;
      hires_ps_mode        <= panel_cfg[PS_MODE_BIT];
      colour_panel         <= panel_cfg[COLOUR_BIT];
      format_two           <= panel_cfg[FMT_SEL_BIT];
      data_width           <= width_f;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  shift_invert_a: assert property (
    is_active && inv_f |=> pixel_shift_clock != $past(sclk_s))
    else $error("active shift clock not inverted");
  shift_plain_a: assert property (
    !inv_eff |=> pixel_shift_clock == $past(sclk_s))
    else $error("shift clock altered without inversion");
  mod_hold_a: assert property (
    !is_passive [*3] |-> $stable(modulation_pin))
    else $error("modulation moved on a non-passive panel");
  frame_toggle_a: assert property (
    is_passive && rate_f == 6'h00 && frame_evt && !wr_cfg
      |-> ##2 modulation_pin != $past(modulation_pin))
    else $error("modulation missed a frame toggle");
  frame_only_a: assert property (
    is_passive && rate_f == 6'h00 && !frame_evt && !wr_cfg
      |-> ##2 $stable(modulation_pin))
    else $error("modulation toggled without a frame");
  format_sel_a: assert property (
    wr_cfg |-> ##2 format_two == $past(reg_wdata[FMT_SEL_BIT], 2))
    else $error("data format flag does not follow write");
  colour_sel_a: assert property (
    wr_cfg |-> ##2 colour_panel == $past(reg_wdata[COLOUR_BIT], 2))
    else $error("colour flag does not follow write");
  width_rsvd_a: assert property (
    width_f == WIDTH_RSVD |=> panel_data == 18'h00000)
    else $error("reserved width drove data lanes");
  width_narrow_a: assert property (
    is_passive && width_f == WIDTH_NARROW |=> panel_data[17:4] == 14'h0)
    else $error("narrow passive width leaked upper lanes");
  type_hires_a: assert property (
    wr_cfg && reg_wdata[1:0] == TYPE_HIRES
      |-> ##2 reflective_hires_tft && active_matrix_panel)
    else $error("hi-res type not decoded");
  rsvd_zero_a: assert property (
    $past(reg_rd && hit_cfg) |-> reg_rdata[RSVD_ZERO_BIT] == 1'b0)
    else $error("reserved bit three read as one");
  rate_restart_a: assert property (
    wr_cfg |=> line_count == 6'h00)
    else $error("rate write did not restart count");

  // Type flags after a write, one edge behind the register
  type_passive_a: assert property (
    wr_cfg && reg_wdata[1:0] == TYPE_PASSIVE
      |-> ##2 passive_matrix_panel && !active_matrix_panel)
    else $error("passive type not decoded");
  type_active_a: assert property (
    wr_cfg && reg_wdata[1:0] == TYPE_ACTIVE
      |-> ##2 active_matrix_panel && !reflective_hires_tft)
    else $error("active type not decoded");
  type_rsvd_a: assert property (
    wr_cfg && reg_wdata[1:0] == TYPE_RSVD
      |-> ##2 !passive_matrix_panel && !active_matrix_panel)
    else $error("reserved type decoded as a panel");

  // Width flag and lane masks per width code and panel kind
  width_flag_a: assert property (
    wr_cfg |-> ##2 data_width == $past(reg_wdata[WIDTH_LSB +: 2], 2))
    else $error("width flag does not follow write");
  width_mid_a: assert property (
    is_passive && width_f == WIDTH_MID |=> panel_data[17:8] == 10'h000)
    else $error("mid passive width leaked upper lanes");
  width_wide_a: assert property (
    is_passive && width_f == WIDTH_WIDE |=> panel_data[17:16] == 2'h0)
    else $error("wide passive width leaked upper lanes");
  act_narrow_a: assert property (
    is_active && width_f == WIDTH_NARROW |=> panel_data[17:9] == 9'h000)
    else $error("narrow active width leaked upper lanes");
  act_mid_a: assert property (
    is_active && width_f == WIDTH_MID |=> panel_data[17:12] == 6'h00)
    else $error("mid active width leaked upper lanes");
  rsvd_data_a: assert property (
    type_f == TYPE_RSVD |=> panel_data == 18'h00000)
    else $error("reserved type drove data lanes");

  // Read data stands for one cycle only
  rdata_idle_a: assert property (
    !reg_rd |=> reg_rdata == 32'h00000000)
    else $error("read data stood without a read");
  cfg_read_a: assert property (
    reg_rd && hit_cfg |=> reg_rdata == $past(panel_cfg))
    else $error("config readback wrong");
  stat_read_a: assert property (
    reg_rd && hit_stat |=> reg_rdata == $past(stat_word))
    else $error("status readback wrong");

  // Pin behaviour against the internal state
  pin_follow_a: assert property (
    ##1 modulation_pin == $past(mod_level))
    else $error("modulation pin lost its level");
  psv_plain_a: assert property (
    is_passive |=> pixel_shift_clock == $past(sclk_s))
    else $error("passive shift clock altered");
  line_only_a: assert property (
    is_passive && rate_f != 6'h00 && !line_evt && !wr_cfg
      |-> ##2 $stable(modulation_pin))
    else $error("modulation toggled without a line");

  line_rate_c: cover property (
    is_passive && rate_f != 6'h00 ##1 $changed(mod_level));
  frame_rate_c: cover property (
    is_passive && rate_f == 6'h00 && frame_evt ##1 $changed(mod_level));
  active_inv_c: cover property (is_active && inv_f && sclk_s);
  cfg_read_c: cover property (reg_rd && hit_cfg);
  hires_inv_c: cover property (is_hires && inv_f && sclk_s);
endmodule

// >>> lcd_cfg_pkg.sv
package lcd_cfg_pkg;
  // Register map, byte addresses on the plain register port
  localparam logic [7:0]  OFF_PANEL_CFG   = 8'h0C;
  localparam logic [7:0]  OFF_MOD_STATUS  = 8'h40;
  localparam logic [31:0] PANEL_CFG_RESET = 32'h00000000;
  // Bits that software can store; bit 3 and n/a bits read zero
  localparam logic [31:0] PANEL_CFG_WMASK = 32'h013F01F3;
  // Field positions inside the panel configuration register
  localparam int SHIFT_INV_BIT   = 24;
  localparam int RATE_LSB        = 16;
  localparam int RATE_W          = 6;
  localparam int PS_MODE_BIT     = 8;
  localparam int FMT_SEL_BIT     = 7;
  localparam int COLOUR_BIT      = 6;
  localparam int WIDTH_LSB       = 4;
  localparam int RSVD_ZERO_BIT   = 3;
  localparam int TYPE_LSB        = 0;
  // Field positions inside the modulation status register
  localparam int STAT_MOD_BIT    = 0;
  localparam int STAT_CNT_LSB    = 8;
  // Panel type codes
  localparam logic [1:0] TYPE_PASSIVE = 2'h0;
  localparam logic [1:0] TYPE_ACTIVE  = 2'h1;
  localparam logic [1:0] TYPE_RSVD    = 2'h2;
  localparam logic [1:0] TYPE_HIRES   = 2'h3;
  // Panel data width codes
  localparam logic [1:0] WIDTH_NARROW = 2'h0;
  localparam logic [1:0] WIDTH_MID    = 2'h1;
  localparam logic [1:0] WIDTH_WIDE   = 2'h2;
  localparam logic [1:0] WIDTH_RSVD   = 2'h3;
  // Data lane masks per width code, passive then active
  localparam logic [17:0] MASK_P4  = 18'h0000F;
  localparam logic [17:0] MASK_P8  = 18'h000FF;
  localparam logic [17:0] MASK_P16 = 18'h0FFFF;
  localparam logic [17:0] MASK_A9  = 18'h001FF;
  localparam logic [17:0] MASK_A12 = 18'h00FFF;
  localparam logic [17:0] MASK_A18 = 18'h3FFFF;
endpackage

// >>> bit_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser for levels from outside the clk domain
module bit_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // Asynchronous level in, synchronised level out
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta     <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule

// >>> ac_mod_gen.sv
`timescale 1ns/1ps
// AC modulation toggle source, per frame or every n line pulses
module ac_mod_gen (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Control
  input  wire logic       enable,
  input  wire logic       restart,
  input  wire logic [5:0] rate,
  // Timing events, one-cycle pulses
  input  wire logic       frame_evt,
  input  wire logic       line_evt,
  // Modulation state
  output logic            ac_modulation_output,
  output logic      [5:0] line_count
);
  logic       next_mod;
  logic [5:0] next_count;
  wire        per_frame = (rate == 6'h00);
  wire        line_wrap = line_evt && (line_count == rate - 6'h01);

  // Count lines continuously; restart clears the interval
  always_comb
  begin
    next_mod   = ac_modulation_output;
    next_count = line_count;
    if (restart || !enable)
      next_count = 6'h00;
    else if (per_frame)
    begin
      next_count = 6'h00;
      if (frame_evt)
        next_mod = !ac_modulation_output;
    end
    else if (line_wrap)
    begin
      next_count = 6'h00;
      next_mod   = !ac_modulation_output;
    end
    else if (line_evt)
      next_count = line_count + 6'h01;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ac_modulation_output <= 1'b0;
      line_count           <= 6'h00;
    end
    else
    begin
      ac_modulation_output <= next_mod;
      line_count           <= next_count;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  restart_clears_a: assert property (
    restart |=> line_count == 6'h00)
    else $error("line counter not cleared by restart");
  line_toggle_a: assert property (
    $changed(ac_modulation_output) && $past(enable && !restart)
      && $past(rate) != 6'h00
      |-> $past(line_evt && line_count == rate - 6'h01))
    else $error("line-rate toggle at wrong count");
  count_bound_a: assert property (
    enable && !per_frame && line_count != 6'h00 |-> line_count < rate)
    else $error("line counter passed the rate");
endmodule

// >>> lcd_panel_model.sv
`timescale 1ns/1ps
// Panel-side timing source for the raw pixel shift clock
module lcd_panel_model (
  // Frame activity from the bench
  input  wire logic run,
  // Raw shift clock towards the controller
  output logic      shift_clock_in
);
  // Parks at its last level between frames, so a stopped clock is legal
  initial shift_clock_in = 1'b0;
  always
  begin
    #62.5;
    if (run)
      shift_clock_in = ~shift_clock_in;
  end
endmodule

// >>> lcd_panel_config_modulation_test.sv
`timescale 1ns/1ps
module lcd_panel_config_modulation_test;
  import lcd_cfg_pkg::*;
  // Design ports
  logic        clk;
  logic        sys_rst;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        shift_clock_in;
  logic        frame_pulse;
  logic        line_pulse;
  logic [17:0] pixel_data_in;
  logic        pixel_shift_clock;
  logic        modulation_pin;
  logic [17:0] panel_data;
  logic        passive_matrix_panel;
  logic        active_matrix_panel;
  logic        reflective_hires_tft;
  logic        hires_ps_mode;
  logic        colour_panel;
  logic        format_two;
  logic [1:0]  data_width;
  // Bench state
  logic        run;
  int          bad_count;
  int          checks_done;
  logic [31:0] seed;
  logic [31:0] cfg;
  logic [5:0]  cnt;
  logic        exp_level;
  int          rates[4];

  lcd_panel_config_modulation dut (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .shift_clock_in(shift_clock_in),
    .frame_pulse(frame_pulse), .line_pulse(line_pulse),
    .pixel_data_in(pixel_data_in), .pixel_shift_clock(pixel_shift_clock),
    .modulation_pin(modulation_pin), .panel_data(panel_data),
    .passive_matrix_panel(passive_matrix_panel),
    .active_matrix_panel(active_matrix_panel),
    .reflective_hires_tft(reflective_hires_tft),
    .hires_ps_mode(hires_ps_mode), .colour_panel(colour_panel),
    .format_two(format_two), .data_width(data_width)
  );

  lcd_panel_model panel (
    .run(run),
    .shift_clock_in(shift_clock_in)
  );

  // Free-running system clock
  always #4 clk = ~clk;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Lanes the panel keeps for a given type and width
  function automatic logic [17:0] exp_data(input logic [31:0] m,
                                           input logic [17:0] p);
    logic [17:0] k;
    case ({m[1:0], m[5:4]})
      4'h0: k = MASK_P4;
      4'h1: k = MASK_P8;
      4'h2: k = MASK_P16;
      4'h4, 4'hC: k = MASK_A9;
      4'h5, 4'hD: k = MASK_A12;
      4'h6, 4'hE: k = MASK_A18;
      default: k = 18'h00000;
    endcase
    return p & k;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    if (bad_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Bus cycles; a spare cycle after each keeps strobes single-driven
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    check(reg_rdata, exp);
    @(posedge clk);
  endtask

  // One configuration: flags, data lanes and shift clock polarity
  task automatic cfg_case(input logic [1:0] t, input logic [1:0] wd);
    logic [31:0] r;
    logic [31:0] p;
    logic        act;
    r = rnd();
    p = rnd();
    r = {r[31:25], wd[1], r[23:6], wd, 1'b0, r[2], t};
    act = (t == TYPE_ACTIVE) || (t == TYPE_HIRES);
    pixel_data_in <= p[17:0];
    wr(OFF_PANEL_CFG, r);
    cfg = r & PANEL_CFG_WMASK;
    run <= 1'b1;
    repeat (p[22:19] + 4) @(posedge clk);
    run <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    check(pixel_shift_clock, shift_clock_in ^ (r[24] & act));
    check(passive_matrix_panel, t == TYPE_PASSIVE);
    check(active_matrix_panel, act);
    check(reflective_hires_tft, t == TYPE_HIRES);
    check(format_two, r[FMT_SEL_BIT]);
    check(colour_panel, r[COLOUR_BIT]);
    check(hires_ps_mode, r[PS_MODE_BIT]);
    check(data_width, wd);
    check(panel_data, exp_data(r, p[17:0]));
    @(posedge clk);
    rd(OFF_PANEL_CFG, cfg);
  endtask

  // Every config write restarts the line count
  task automatic set_rate(input logic [1:0] t, input logic [5:0] n);
    cfg = 32'h00000000;
    cfg[1:0] = t;
    cfg[21:16] = n;
    wr(OFF_PANEL_CFG, cfg);
    cnt = 6'h00;
  endtask

  // One frame or line pulse, then the expected level and count
  task automatic step(input logic fr);
    logic [5:0] n;
    logic       psv;
    n   = cfg[21:16];
    psv = (cfg[1:0] == TYPE_PASSIVE);
    frame_pulse <= fr;
    line_pulse  <= ~fr;
    @(posedge clk);
    frame_pulse <= 1'b0;
    line_pulse  <= 1'b0;
    repeat (4) @(posedge clk);
    if (psv && !fr && n != 6'h00)
      cnt = cnt + 6'h01;
    if (psv && ((fr && n == 6'h00) || (n != 6'h00 && cnt == n)))
    begin
      exp_level = ~exp_level;
      cnt       = 6'h00;
    end
    #1;
    check(modulation_pin, exp_level);
    @(posedge clk);
    rd(OFF_MOD_STATUS, {18'h00000, cnt, 7'h00, exp_level});
  endtask

  // Main sequence
  initial
  begin
    clk = 1'b0;
    sys_rst = 1'b1;
    {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    {frame_pulse, line_pulse, pixel_data_in, run} = '0;
    {bad_count, checks_done} = '0;
    seed = 32'h000125D3;
    exp_level = 1'b0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rd(OFF_PANEL_CFG, PANEL_CFG_RESET);
    check(passive_matrix_panel, 1'b1);
    for (int t = 0; t < 4; t++)
      for (int w = 0; w < 4; w++)
        cfg_case(t[1:0], w[1:0]);
    wr(8'h44, rnd());
    rd(8'h44, 32'h00000000);
    rd(OFF_PANEL_CFG, cfg);
    set_rate(TYPE_PASSIVE, 6'h00);
    repeat (3) step(1'b1);
    rates = '{1, 2, 63, 0};
    seed = rnd();
    rates[3] = seed[4:0] + 3;
    for (int k = 0; k < 4; k++)
    begin
      set_rate(TYPE_PASSIVE, rates[k][5:0]);
      repeat (2 * rates[k]) step(1'b0);
      step(1'b1);
      repeat (rates[k] - 1) step(1'b0);
      set_rate(TYPE_PASSIVE, rates[k][5:0]);
      repeat (rates[k]) step(1'b0);
    end
    set_rate(TYPE_ACTIVE, 6'h02);
    repeat (3) step(1'b0);
    set_rate(TYPE_HIRES, 6'h00);
    repeat (2) step(1'b1);
    wr(OFF_MOD_STATUS, 32'hFFFFFFFF);
    rd(OFF_MOD_STATUS, {18'h00000, cnt, 7'h00, exp_level});
    final_report();
  end

  // Watchdog well beyond the expected run length
  initial
  begin
    #400000;
    bad_count++;
    final_report();
  end
endmodule
